// ### hdl/ats_translation_service.sv
// Root-complex translation service: answers endpoint translation requests
// and forwards translated peer requests with a fresh end-to-end CRC.
// Assumes an external table walker with a pulse handshake, synchronous inputs.
`timescale 1ns/1ps
module ats_translation_service #(
  parameter int unsigned MAX_ENTRIES = 8  // Largest entry count returned
) (
  input  wire logic        sys_clk,         // System clock, 50 MHz
  input  wire logic        reset_n,         // Async reset, active low
  input  wire logic [3:0]  reg_addr,        // Register byte address
  input  wire logic [31:0] reg_wdata,       // Register write data
  input  wire logic        reg_wr,          // Write strobe
  input  wire logic        reg_rd,          // Read strobe
  output logic [31:0]      reg_rdata,       // Read data, cycle after strobe
  input  wire logic        req_valid,       // Upstream request present
  input  wire logic [1:0]  req_at,          // Address type
  input  wire logic        req_is_write,    // Memory write
  input  wire logic        req_has_pasid,   // PASID prefix present
  input  wire logic [19:0] req_pasid,       // PASID value
  input  wire logic        req_er,          // Execute requested
  input  wire logic        req_pr,          // Privileged mode requested
  input  wire logic        req_nw,          // No-write requested
  input  wire logic [63:0] req_addr,        // Input address
  input  wire logic [9:0]  req_len,         // Length in dwords
  input  wire logic [3:0]  req_first_be,    // First dword byte enables
  input  wire logic [3:0]  req_last_be,     // Last dword byte enables
  output logic             req_ready,       // Ready for a new request
  input  wire logic        p2p_valid,       // Peer request present
  input  wire logic [63:0] p2p_addr,        // Peer input address
  input  wire logic [63:0] p2p_hdr,         // Other header dwords
  input  wire logic        p2p_has_ecrc,    // Peer request has ECRC
  output logic             walk_req,        // Walker request pulse
  output logic [51:0]      walk_pn,         // Input page number to walk
  output logic             walk_pasid_en,   // Walk with PASID
  output logic [19:0]      walk_pasid,      // PASID for the walk
  output logic             walk_nw,         // Read-only access wanted
  output logic             walk_er,         // Execute wanted
  output logic             walk_pr,         // Privileged access wanted
  input  wire logic        walk_done,       // Walker result pulse
  input  wire logic        walk_err,        // Walk hit an error
  input  wire logic [51:0] walk_hpa,        // Host physical page number
  input  wire logic [5:0]  walk_shift,      // Page size log2, 12 upward
  input  wire logic        walk_r,          // Read allowed
  input  wire logic        walk_w,          // Write allowed
  input  wire logic        walk_x,          // Execute allowed
  input  wire logic        walk_priv,       // Privileged permissions
  input  wire logic        walk_g,          // Global mapping
  input  wire logic        walk_n,          // No-snoop required
  input  wire logic        walk_u,          // Untranslated only
  output logic             cpl_valid,       // Completion header pulse
  output logic [2:0]       cpl_status,      // Completion status
  output logic             cpl_has_data,    // Completion carries entries
  output logic [9:0]       cpl_count,       // Entry count
  output logic             ent_valid,       // Entry pulse
  output logic [63:0]      ent_data,        // Translation entry
  output logic             ent_last,        // Final entry
  output logic             malformed,       // Malformed request pulse
  output logic             pass_valid,      // Non-translation request passed
  output logic             fwd_valid,       // Peer forward pulse
  output logic [63:0]      fwd_addr,        // Peer address, translated when remap is on
  output logic [63:0]      fwd_hdr,         // Other header dwords
  output logic             fwd_has_ecrc,    // ECRC field present
  output logic [31:0]      fwd_ecrc,        // Recomputed ECRC
  output logic             p2p_block        // Peer request refused pulse
);
  import ats_pkg::*;

  ats_state_e  state, next_state;
  logic [2:0]  ctrl, next_ctrl;
  logic [31:0] peer_base, next_peer_base, peer_limit, next_peer_limit;
  logic [7:0]  ur_cnt, next_ur_cnt, ca_cnt, next_ca_cnt, blk_cnt, next_blk_cnt;
  logic [9:0]  left, next_left;
  logic [5:0]  stride, next_stride;
  logic        first, next_first;
  logic [31:0] next_rdata;
  logic        next_ready, next_walk_req, next_walk_pasid_en, next_walk_nw;
  logic        next_walk_er, next_walk_pr, next_cpl_valid, next_cpl_has_data;
  logic        next_ent_valid, next_ent_last, next_malformed, next_pass_valid;
  logic        next_fwd_valid, next_fwd_has_ecrc, next_p2p_block;
  logic [51:0] next_walk_pn;
  logic [19:0] next_walk_pasid;
  logic [2:0]  next_cpl_status;
  logic [9:0]  next_cpl_count, n_req;
  logic [63:0] next_ent_data, next_fwd_addr, next_fwd_hdr;
  logic        crc_start, crc_done;
  logic [31:0] crc_val;
  logic        peer_ok;

  // Pack one entry: size encoding, permission qualifiers
  function automatic logic [63:0] ats_entry(
    input logic [51:0] host_physical_address, input logic [5:0] shift, input logic pasid,
    input logic r, input logic w, input logic x, input logic pv,
    input logic g, input logic n, input logic u);
    logic [63:0] e;
    logic [5:0]  k;
    e = 64'h0;
    k = shift - PAGE_SHIFT_MIN;
    for (int i = 0; i < 52; i++) begin
      if (k != 6'h0 && i < int'(k) - 1) begin
        e[12+i] = 1'b1;
      end else if (k != 6'h0 && i == int'(k) - 1) begin
        e[12+i] = 1'b0;
      end else begin
        e[12+i] = host_physical_address[i];
      end
    end
    if (!(r || w) || u) begin
      e[63:12] = 52'h0;
    end
    e[ENT_S]    = (k != 6'h0);
    e[ENT_R]    = r;
    e[ENT_W]    = w;
    e[ENT_N]    = n;
    e[ENT_U]    = u;
    e[ENT_EXE]  = pasid & x & r;
    e[ENT_PRIV] = pasid & pv;
    e[ENT_G]    = pasid & g;
    return e;
  endfunction : ats_entry

  // Peer window on page number of the translated address
  assign peer_ok = ctrl[CTRL_PEER_EN] && (walk_hpa[51:32] == 20'h0) &&
                   (walk_hpa[31:0] >= peer_base) && (walk_hpa[31:0] <= peer_limit);
  assign crc_start = (state == ST_P2P_WALK) && walk_done && !walk_err && peer_ok;

  ats_ecrc u_ecrc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (crc_start),
    .data    ({fwd_hdr, walk_hpa, fwd_addr[11:0]}),
    .done    (crc_done),
    .crc     (crc_val)
  );

  // Entry count requested, capped
  always_comb begin
    n_req = (req_len == 10'h0) ? LEN_ZERO_ENTS : {1'b0, req_len[9:1]};
    if (n_req > 10'(MAX_ENTRIES)) begin
      n_req = 10'(MAX_ENTRIES);
    end
  end

  // Next values of registers, sequencer and outputs
  always_comb begin
    next_state = state;       next_ctrl = ctrl;
    next_peer_base = peer_base;  next_peer_limit = peer_limit;
    next_ur_cnt = ur_cnt;     next_ca_cnt = ca_cnt;   next_blk_cnt = blk_cnt;
    next_left = left;         next_stride = stride;   next_first = first;
    next_walk_req = 1'b0;     next_walk_pn = walk_pn;
    next_walk_pasid_en = walk_pasid_en;  next_walk_pasid = walk_pasid;
    next_walk_nw = walk_nw;   next_walk_er = walk_er; next_walk_pr = walk_pr;
    next_cpl_valid = 1'b0;    next_cpl_status = cpl_status;
    next_cpl_has_data = cpl_has_data;    next_cpl_count = cpl_count;
    next_ent_valid = 1'b0;    next_ent_data = ent_data;  next_ent_last = 1'b0;
    next_malformed = 1'b0;    next_pass_valid = 1'b0;
    next_fwd_valid = 1'b0;    next_fwd_addr = fwd_addr;  next_fwd_hdr = fwd_hdr;
    next_fwd_has_ecrc = fwd_has_ecrc;    next_p2p_block = 1'b0;
    next_rdata = 32'h0;
    // Register port
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:       next_ctrl = reg_wdata[2:0];
        REG_PEER_BASE:  next_peer_base = reg_wdata;
        REG_PEER_LIMIT: next_peer_limit = reg_wdata;
        default:        next_ctrl = ctrl;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:       next_rdata = {29'h0, ctrl};
        REG_PEER_BASE:  next_rdata = peer_base;
        REG_PEER_LIMIT: next_rdata = peer_limit;
        REG_STATUS:     next_rdata = {state != ST_IDLE, 7'h0, blk_cnt, ca_cnt, ur_cnt};
        default:        next_rdata = 32'h0;
      endcase
    end
    unique case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_cpl_status = CPL_UR;
          next_cpl_has_data = 1'b0;
          next_cpl_count = 10'h0;
          if (req_at == AT_RSVD || (req_at == AT_XLATE_REQ && req_is_write) ||
              (req_at == AT_XLATED && req_has_pasid)) begin
            next_cpl_valid = 1'b1;
            next_ur_cnt = ur_cnt + 8'h01;
          end else if (req_at == AT_XLATE_REQ) begin
            if (req_len[0] || req_first_be != BE_FULL || req_last_be != BE_FULL) begin
              next_malformed = 1'b1;
            end else if (!ctrl[CTRL_ATS_EN]) begin
              next_cpl_valid = 1'b1;
              next_ur_cnt = ur_cnt + 8'h01;
            end else begin
              next_state = ST_WALK;
              next_walk_req = 1'b1;
              next_walk_pn = req_addr[63:12];
              next_walk_pasid_en = req_has_pasid;
              next_walk_pasid = req_pasid;
              next_walk_nw = req_nw;
              next_walk_er = req_er;
              next_walk_pr = req_pr;
              next_left = n_req;
              next_cpl_count = n_req;
              next_first = 1'b1;
            end
          end else begin
            next_pass_valid = 1'b1;
          end
        end else if (p2p_valid) begin
          next_fwd_hdr = p2p_hdr;
          next_fwd_has_ecrc = p2p_has_ecrc;
          next_fwd_addr = p2p_addr;
          if (ctrl[CTRL_REMAP_EN]) begin
            next_state = ST_P2P_WALK;
            next_walk_req = 1'b1;
            next_walk_pn = p2p_addr[63:12];
            next_walk_pasid_en = 1'b0;
          end else if (!ctrl[CTRL_PEER_EN]) begin
            next_p2p_block = 1'b1;
            next_blk_cnt = blk_cnt + 8'h01;
          end else begin
            next_fwd_valid = 1'b1;
          end
        end
      end
      ST_WALK: begin
        if (walk_done) begin
          if (first && walk_err) begin
            next_cpl_valid = 1'b1;
            next_cpl_status = CPL_CA;
            next_cpl_has_data = 1'b0;
            next_ca_cnt = ca_cnt + 8'h01;
            next_state = ST_IDLE;
          end else begin
            next_cpl_valid = first;
            next_cpl_status = CPL_SC;
            next_cpl_has_data = 1'b1;
            next_ent_valid = 1'b1;
            next_ent_data = ats_entry(walk_hpa, first ? walk_shift : stride,
                                      walk_pasid_en, walk_r & ~walk_err,
                                      walk_w & ~walk_err & ~walk_nw, walk_x,
                                      walk_priv, walk_g, walk_n, walk_u);
            if (first) begin
              next_stride = walk_shift;
            end
            next_first = 1'b0;
            next_left = left - 10'h001;
            if (left == 10'h001) begin
              next_ent_last = 1'b1;
              next_state = ST_IDLE;
            end else begin
              next_walk_req = 1'b1;
              next_walk_pn = walk_pn + (52'h1 << ((first ? walk_shift : stride)
                             - PAGE_SHIFT_MIN));
            end
          end
        end
      end
      ST_P2P_WALK: begin
        if (walk_done) begin
          next_fwd_addr = {walk_hpa, fwd_addr[11:0]};
          if (walk_err || !peer_ok) begin
            next_p2p_block = 1'b1;
            next_blk_cnt = blk_cnt + 8'h01;
            next_state = ST_IDLE;
          end else begin
            next_state = ST_P2P_CRC;
          end
        end
      end
      ST_P2P_CRC: begin
        if (crc_done) begin
          next_fwd_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  // State and output registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;        ctrl <= CTRL_RESET;
      peer_base <= PEER_RESET; peer_limit <= PEER_RESET;
      ur_cnt <= 8'h00;         ca_cnt <= 8'h00;        blk_cnt <= 8'h00;
      left <= 10'h000;         stride <= PAGE_SHIFT_MIN; first <= 1'b0;
      reg_rdata <= 32'h0;      req_ready <= 1'b1;
      walk_req <= 1'b0;        walk_pn <= 52'h0;       walk_pasid_en <= 1'b0;
      walk_pasid <= 20'h0;     walk_nw <= 1'b0;        walk_er <= 1'b0;
      walk_pr <= 1'b0;         cpl_valid <= 1'b0;      cpl_status <= CPL_SC;
      cpl_has_data <= 1'b0;    cpl_count <= 10'h000;   ent_valid <= 1'b0;
      ent_data <= 64'h0;       ent_last <= 1'b0;       malformed <= 1'b0;
      pass_valid <= 1'b0;      fwd_valid <= 1'b0;      fwd_addr <= 64'h0;
      fwd_hdr <= 64'h0;        fwd_has_ecrc <= 1'b0;   p2p_block <= 1'b0;
      fwd_ecrc <= 32'h0;
    end else begin
      state <= next_state;     ctrl <= next_ctrl;
      peer_base <= next_peer_base;  peer_limit <= next_peer_limit;
      ur_cnt <= next_ur_cnt;   ca_cnt <= next_ca_cnt;  blk_cnt <= next_blk_cnt;
      left <= next_left;       stride <= next_stride;  first <= next_first;
      reg_rdata <= next_rdata; req_ready <= next_ready;
      walk_req <= next_walk_req;    walk_pn <= next_walk_pn;
      walk_pasid_en <= next_walk_pasid_en;  walk_pasid <= next_walk_pasid;
      walk_nw <= next_walk_nw; walk_er <= next_walk_er; walk_pr <= next_walk_pr;
      cpl_valid <= next_cpl_valid;  cpl_status <= next_cpl_status;
      cpl_has_data <= next_cpl_has_data;    cpl_count <= next_cpl_count;
      ent_valid <= next_ent_valid;  ent_data <= next_ent_data;
      ent_last <= next_ent_last;    malformed <= next_malformed;
      pass_valid <= next_pass_valid;  fwd_valid <= next_fwd_valid;
      fwd_addr <= next_fwd_addr;    fwd_hdr <= next_fwd_hdr;
      fwd_has_ecrc <= next_fwd_has_ecrc;    p2p_block <= next_p2p_block;
      fwd_ecrc <= crc_done ? crc_val : fwd_ecrc;
    end
  end

  // Checks on the answers
  ur_pasid_xlated_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && req_valid && req_at == AT_XLATED && req_has_pasid)
    |=> cpl_valid && cpl_status == CPL_UR && !cpl_has_data)
    else $error("PASID translated request not refused");
  malformed_req_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && req_valid && req_at == AT_XLATE_REQ && !req_is_write &&
     (req_len[0] || req_first_be != BE_FULL)) |=> malformed && !cpl_valid)
    else $error("Malformed translation request not flagged");
  ats_off_ur_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_IDLE && req_valid && req_at == AT_XLATE_REQ && !req_is_write &&
     !req_len[0] && req_first_be == BE_FULL && req_last_be == BE_FULL &&
     !ctrl[CTRL_ATS_EN]) |=> cpl_valid && cpl_status == CPL_UR && !walk_req)
    else $error("Disabled translation not answered with UR");
  walk_err_ca_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_WALK && walk_done && walk_err && first)
    |=> cpl_valid && cpl_status == CPL_CA && !cpl_has_data && !ent_valid)
    else $error("Walk error not answered with CA");
  success_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cpl_valid && cpl_status == CPL_SC) |-> cpl_has_data && ent_valid)
    else $error("Successful completion without entry");
  exe_needs_r_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ent_valid && ent_data[ENT_EXE]) |-> ent_data[ENT_R])
    else $error("Execute granted without read");
  addr_valid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ent_valid && (ent_data[ENT_U] || !(ent_data[ENT_R] || ent_data[ENT_W])))
    |-> ent_data[63:12] == 52'h0)
    else $error("Address shown for unusable translation");
  peer_crc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    crc_start |=> crc_done ##1 (fwd_valid && fwd_ecrc == $past(crc_val)))
    else $error("Peer forward missing recomputed CRC");
  peer_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == ST_P2P_WALK && walk_done && !peer_ok) |=> p2p_block && !fwd_valid)
    else $error("Peer request outside window forwarded");

endmodule : ats_translation_service

// ### hdl/ats_pkg.sv
// Shared constants for the address translation service block.
// Assumes a single 50 MHz clock domain and PCI Express style field codes.
package ats_pkg;

  // Address type codes of a memory request
  localparam logic [1:0] AT_UNTRANS   = 2'h0;
  localparam logic [1:0] AT_XLATE_REQ = 2'h1;
  localparam logic [1:0] AT_XLATED    = 2'h2;
  localparam logic [1:0] AT_RSVD      = 2'h3;

  // Byte enables and completion status codes
  localparam logic [3:0] BE_FULL = 4'hF;
  localparam logic [2:0] CPL_SC  = 3'h0;
  localparam logic [2:0] CPL_UR  = 3'h1;
  localparam logic [2:0] CPL_CA  = 3'h4;

  // Page geometry; each returned translation is eight bytes
  localparam logic [5:0] PAGE_SHIFT_MIN = 6'h0C;
  localparam logic [9:0] LEN_ZERO_ENTS  = 10'h200;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_PEER_BASE  = 4'h4;
  localparam logic [3:0] REG_PEER_LIMIT = 4'h8;
  localparam logic [3:0] REG_STATUS     = 4'hC;

  // Control bits and reset values
  localparam int          CTRL_ATS_EN   = 0;
  localparam int          CTRL_PEER_EN  = 1;
  localparam int          CTRL_REMAP_EN = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  localparam logic [31:0] PEER_RESET    = 32'h0000_0000;
  localparam int          STAT_BUSY     = 31;

  // Bit positions inside one 64-bit translation entry
  localparam int ENT_R    = 0;
  localparam int ENT_W    = 1;
  localparam int ENT_N    = 2;
  localparam int ENT_U    = 3;
  localparam int ENT_EXE  = 4;
  localparam int ENT_PRIV = 5;
  localparam int ENT_G    = 6;
  localparam int ENT_S    = 11;

  typedef enum {ST_IDLE, ST_WALK, ST_P2P_WALK, ST_P2P_CRC} ats_state_e;

endpackage : ats_pkg

// ### hdl/ats_ecrc.sv
// CRC-32 engine that recomputes the end-to-end CRC of a rewritten header.
// Assumes start is a one-cycle pulse; result stands one cycle later.
`timescale 1ns/1ps
module ats_ecrc (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         reset_n,  // Async reset, active low
  input  wire logic         start,    // Compute pulse
  input  wire logic [127:0] data,     // Header bits, msb first
  output logic              done,     // Result valid pulse
  output logic [31:0]       crc       // Recomputed CRC
);
  import ats_pkg::*;

  logic        next_done;
  logic [31:0] next_crc;

  // Bitwise CRC-32 over the full header
  function automatic logic [31:0] ats_crc32(input logic [127:0] d);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 127; i >= 0; i--) begin
      if (c[31] ^ d[i]) begin
        c = {c[30:0], 1'b0} ^ 32'h04C1_1DB7;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    return ~c;
  endfunction : ats_crc32

  // Next result
  always_comb begin
    next_done = start;
    next_crc  = start ? ats_crc32(data) : crc;
  end

  // Result registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
      crc  <= 32'h0000_0000;
    end else begin
      done <= next_done;
      crc  <= next_crc;
    end
  end

endmodule : ats_ecrc

// ### bench/ats_walker_model.sv
// Table walker model: answers every walk request three cycles later.
// Assumes walk_pn stands until the answer; attr bit 7 asks for an error.
`timescale 1ns/1ps
module ats_walker_model (
  input  wire logic        sys_clk,   // System clock
  input  wire logic        walk_req,  // Walk request pulse
  input  wire logic [51:0] walk_pn,   // Page to walk
  input  wire logic [7:0]  attr,      // Error, G PRIV X U N W R
  output logic             walk_done, // Answer pulse
  output logic             walk_err,  // Walk failed
  output logic [51:0]      walk_hpa,  // Host physical page
  output logic [6:0]       walk_attr  // Returned attributes
);
  logic [1:0] pend = 2'h0;
  // Fixed delay; result lines carry other values outside the answer
  always @(posedge sys_clk) begin
    pend      <= {pend[0], walk_req};
    walk_done <= pend[1];
    walk_err  <= pend[1] & attr[7];
    walk_hpa  <= pend[1] ? walk_pn ^ 52'hA5 : ~walk_pn;
    walk_attr <= pend[1] ? attr[6:0] : ~attr[6:0];
  end
endmodule : ats_walker_model

// ### bench/tb_top.sv
// Bench for the translation service: random requests, walker model, registers.
// Assumes one clock; the walker answers after a fixed delay, page size is driven here.
`timescale 1ns/1ps
module tb_top;
  import ats_pkg::*;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, req_valid = 0, req_is_write = 0;
  logic req_has_pasid = 0, req_er = 0, req_pr = 0, req_nw = 0, p2p_valid = 0, p2p_has_ecrc = 0;
  logic req_ready, walk_req, cpl_valid, ent_valid, malformed, pass_valid, walk_pasid_en;
  logic walk_nw, walk_er, walk_pr, cpl_has_data, ent_last, fwd_valid, fwd_has_ecrc, p2p_block;
  logic walk_done, walk_err, walk_r, walk_w, walk_x, walk_priv, walk_g, walk_n, walk_u;
  logic [1:0]  req_at = 0;
  logic [2:0]  cpl_status;
  logic [3:0]  reg_addr = 0, req_first_be = 0, req_last_be = 0;
  logic [5:0]  walk_shift = 6'h0C;
  logic [7:0]  attr = 0;
  logic [9:0]  req_len = 0, cpl_count;
  logic [19:0] req_pasid = 0, walk_pasid;
  logic [31:0] reg_wdata = 0, reg_rdata, fwd_ecrc;
  logic [51:0] walk_pn, walk_hpa;
  logic [63:0] req_addr = 0, p2p_addr = 0, p2p_hdr = 0, ent_data, fwd_addr, fwd_hdr, ents [8];
  int n_mismatch = 0, check_count = 0, cyc = 0, seed = 40694, kind, ne, lastn;
  ats_translation_service i_ats_translation_service (.*);
  ats_walker_model i_ats_walker_model (.*,
    .walk_attr({walk_g, walk_priv, walk_x, walk_u, walk_n, walk_w, walk_r}));
  // Clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) chk(0, 1);
    if (cyc == 4000) test_done();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic rg(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1 if (!wr) chk(reg_rdata, d);
  endtask : rg
  // Expected entry: size-encoded host page and permission bits
  function automatic logic [63:0] exp_ent(input logic [51:0] pn, input int k);
    logic [51:0] a;
    a = pn ^ 52'hA5;
    if (k > 0) a = (a & ~((52'h1 << k) - 52'h1)) | ((52'h1 << (k - 1)) - 52'h1);
    return {attr[3] ? 52'h0 : a, k > 0, 4'h0, attr[6:4] & {3{req_has_pasid}}, attr[3:2],
            attr[1] & ~req_nw, attr[0]};
  endfunction : exp_ent
  // Reference CRC-32 of a forwarded header, msb first
  function automatic logic [31:0] exp_crc(input logic [127:0] d);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 127; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0);
    return ~c;
  endfunction : exp_crc
  // One peer request, then wait for the forward or the refusal
  task automatic pr(input logic remap, input int exp);
    logic [63:0] xa;
    @(posedge sys_clk);
    {p2p_valid, p2p_has_ecrc} <= 2'h3;
    p2p_addr <= {20'h0, 12'($random(seed)) | 12'h800, 32'($random(seed))};
    p2p_hdr <= {$random(seed), $random(seed)};
    @(posedge sys_clk);
    p2p_valid <= 0;
    kind = 0;
    for (int k = 0; k < 40 && kind == 0; k++) begin
      #1 kind = (fwd_valid === 1) ? 1 : (p2p_block === 1) ? 2 : 0;
      @(posedge sys_clk);
    end
    chk(kind, exp);
    xa = remap ? {p2p_addr[63:12] ^ 52'hA5, p2p_addr[11:0]} : p2p_addr;
    if (exp == 1) chk(fwd_addr, xa);
    if (exp == 1) chk(fwd_hdr, p2p_hdr);
    if (exp == 1) chk(fwd_has_ecrc, 1);
    if (remap && exp == 1) chk(fwd_ecrc, exp_crc({p2p_hdr, xa}));
  endtask : pr
  // One request, then collect the answer and entries until ready again
  task automatic go(input logic [1:0] at, input logic w, p, input logic [9:0] len,
                    input logic [3:0] be, input int exp);
    @(posedge sys_clk);
    {req_valid, req_at, req_is_write, req_has_pasid, req_len, req_first_be, req_last_be}
      <= {1'b1, at, w, p, len, be, be};
    req_addr <= {$random(seed), $random(seed)};
    {req_nw, req_er, req_pr, req_pasid} <= 23'($random(seed));
    @(posedge sys_clk);
    req_valid <= 0;
    kind = 0;
    ne = 0;
    lastn = 0;
    // Pulses stand right after the edge that takes the request, for one cycle
    for (int k = 0; k < 40 && !(kind > 0 && req_ready === 1); k++) begin
      #1;
      if (cpl_valid === 1) kind = 16 + {cpl_has_data, cpl_status};
      if (malformed === 1) kind = 8;
      if (pass_valid === 1) kind = 9;
      if (ent_valid === 1) ents[ne[2:0]] = ent_data;
      if (ent_valid === 1) ne++;
      if (ent_last === 1) lastn = ne;
      @(posedge sys_clk);
    end
    chk(kind, exp);
  endtask : go
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1;
    rg(0, REG_CTRL, 0);
    rg(0, 4'h2, 0);
    go(AT_XLATE_REQ, 0, 0, 4, BE_FULL, 17);
    rg(1, REG_CTRL, 1);
    go(AT_RSVD, 0, 0, 4, BE_FULL, 17);
    go(AT_XLATE_REQ, 1, 0, 4, BE_FULL, 17);
    go(AT_XLATED, 0, 1, 4, BE_FULL, 17);
    go(AT_XLATE_REQ, 0, 0, 3, BE_FULL, 8);
    go(AT_XLATE_REQ, 0, 1, 4, 4'h7, 8);
    go(AT_UNTRANS, 0, 0, 4, BE_FULL, 9);
    for (int i = 0; i < 6; i++) begin
      attr <= {1'b0, 7'($random(seed))} | 8'h01;
      walk_shift <= 6'(12 + i % 3);
      go(AT_XLATE_REQ, 0, i[0], 4, BE_FULL, 24);
      chk(ne, 2);
      chk(lastn, 2);
      chk(cpl_count, 2);
      chk({walk_pasid_en, walk_pasid}, {req_has_pasid, req_pasid});
      chk({walk_nw, walk_er, walk_pr}, {req_nw, req_er, req_pr});
      chk(ents[0], exp_ent(req_addr[63:12], i % 3));
      chk(ents[1], exp_ent(req_addr[63:12] + (52'h1 << (i % 3)), i % 3));
    end
    attr <= 8'h81;
    go(AT_XLATE_REQ, 0, 0, 4, BE_FULL, 20);
    chk(ne, 0);
    rg(0, REG_STATUS, 32'h0000_0104);
    attr <= 8'h00;
    pr(0, 2);
    rg(1, REG_PEER_LIMIT, 32'hFFFF_FFFF);
    rg(1, REG_CTRL, 3);
    pr(0, 1);
    rg(1, REG_CTRL, 7);
    pr(1, 1);
    rg(0, REG_PEER_LIMIT, 32'hFFFF_FFFF);
    rg(1, REG_PEER_LIMIT, 0);
    pr(1, 2);
    rg(0, REG_STATUS, 32'h0002_0104);
    test_done();
  end
endmodule : tb_top
